/* File: serial_infrared_pulse_codec_cfg.svh */
`ifndef SERIAL_INFRARED_PULSE_CODEC_CFG_SVH
`define SERIAL_INFRARED_PULSE_CODEC_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SIR_ADR_W           8
`define SIR_OFS_CTRL        8'h00
`define SIR_OFS_STATUS      8'h04

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SIR_CTRL_W          6
`define SIR_CTRL_RATE_LSB   0
`define SIR_CTRL_RATE_MSB   2
`define SIR_CTRL_EXT_CLK    3
`define SIR_CTRL_FIXED      4
`define SIR_CTRL_OSC_PD     5
`define SIR_CTRL_RESET      6'h00

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SIR_STAT_ENC_BUSY   0
`define SIR_STAT_DEC_BUSY   1
`define SIR_STAT_OSC_PD     2
`define SIR_STAT_PENDING    3
`define SIR_STAT_LEVEL_LSB  4
`define SIR_STAT_COUNT_LSB  8
`define SIR_STAT_STAMP_LSB  16

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define SIR_BIT_TICKS       16
`define SIR_ENC_PRE_TICKS   7
`define SIR_ENC_HIGH_TICKS  3
`define SIR_MONO_XTAL       6
`define SIR_DIV_W           7
`define SIR_FIFO_DEPTH      4
`define SIR_STAMP_W         8

`endif

/* File: serial_infrared_pulse_codec_pkg.sv */
package serial_infrared_pulse_codec_pkg;
`include "serial_infrared_pulse_codec_cfg.svh"

  typedef enum logic [1:0]
  {
    ENC_IDLE = 2'h0,
    ENC_BIT  = 2'h1
  } enc_state_type;

  typedef enum logic [1:0]
  {
    DEC_IDLE    = 2'h0,
    DEC_STRETCH = 2'h1
  } dec_state_type;

  typedef struct packed
  {
    logic [2:0]              xclk_sync;
    logic [2:0]              xtal_sync;
    logic [2:0]              tx_sync;
    logic [2:0]              rx_sync;
    logic [`SIR_DIV_W-1:0]   div_cnt;
    logic [`SIR_STAMP_W-1:0] tick_cnt;
    enc_state_type           enc_st;
    logic [3:0]              enc_cnt;
    logic                    enc_hi;
    logic [2:0]              mono_cnt;
    logic                    tx_out;
    dec_state_type           dec_st;
    logic [3:0]              dec_cnt;
    logic                    rx_out;
    logic                    pend;
    logic [`SIR_STAMP_W-1:0] pend_stamp;
    logic [`SIR_STAMP_W-1:0] last_stamp;
    logic [7:0]              rx_count;
    logic [`SIR_CTRL_W-1:0]  ctrl;
    logic                    ack;
    logic [31:0]             rdata;
  } codec_state_type;

endpackage

/* File: sir_pulse_fifo.sv */
`timescale 1ns/1ps
module sir_pulse_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Filling side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [WIDTH-1:0]         in_data_i,
  // Draining side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [WIDTH-1:0]              out_data_o,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]    level_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } fifo_state_type;

  fifo_state_type q;
  fifo_state_type d;
  logic           push;
  logic           pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH-1)) ? '0 : p + AW'(1);
  endfunction

  assign in_ready_o  = (q.cnt != CW'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rd];
  assign level_o     = q.cnt;

  always_comb
  begin
    d    = q;
    push = in_valid_i && in_ready_o;
    pop  = out_valid_o && out_ready_i;
    if (push)
    begin
      d.mem[q.wr] = in_data_i;
      d.wr        = next_ptr(q.wr);
    end
    if (pop)
    begin
      d.rd = next_ptr(q.rd);
    end
    if (push && !pop)
    begin
      d.cnt = q.cnt + CW'(1);
    end
    else if (pop && !push)
    begin
      d.cnt = q.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

/* File: serial_infrared_pulse_codec.sv */
// Function
// - Encode and decode advance on rising edges of the 16x sample clock.
// - Falling edge on serial transmit input starts infrared modulation.
// - Serial receive output carries demodulated infrared receive input.
// - Clock select high uses external sample clock, low the crystal divider.
// - External clock selected forces crystal oscillator power-down.
// - Active-low codec reset holds encode and decode machines reset.
// - Accept 3/16 bit or 1.6 us received pulses, demodulate both.
// - Fixed-pulse mode fires six crystal cycle pulse on modulation rise.
// - Fixed-pulse mode defaults low, selecting 3/16 modulation.
// - Power-down bit stops only the oscillator cell, nothing else.
// - Two transmit pulse modes, 3/16 bit and fixed width; receive decodes either width in both modes.
// - Zero bit: wait seven ticks, high three ticks, repeat per zero bit.
// - Each received falling edge drives receive output low sixteen ticks; one arriving while another waits on a full queue replaces it.
// - Crystal divided by 2,4,12,24,6,48,96 per code; 111 undivided.
// - Fixed pulse is six crystal cycles regardless of rate code.
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module serial_infrared_pulse_codec
  import serial_infrared_pulse_codec_pkg::*;
#(
  parameter int FIFO_DEPTH = `SIR_FIFO_DEPTH,
  parameter int BIT_TICKS  = `SIR_BIT_TICKS,
  parameter int MONO_XTAL  = `SIR_MONO_XTAL
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        codec_reset_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Clock sources
  input  wire logic        ext_sample_clk_i,
  input  wire logic        crystal_clk_i,
  output logic             crystal_osc_pd_o,
  // UART side
  input  wire logic        serial_tx_i,
  output logic             serial_rx_out_o,
  // Optical side
  output logic             optical_tx_out_o,
  input  wire logic        optical_rx_in_n_i
);

  localparam int SW = `SIR_STAMP_W;
  localparam int LW = $clog2(FIFO_DEPTH+1);

  codec_state_type q;
  codec_state_type d;

  logic            ext_sel;
  logic            fixed_mode;
  logic [2:0]      rate_code;
  logic [6:0]      divisor;
  logic            xclk_rise;
  logic            xtal_rise;
  logic            tick;
  logic            tx_fall;
  logic            rx_fall;
  logic            pulse_on;
  logic            fifo_rst;
  logic            push_ready;
  logic            pop_valid;
  logic            pop_ready;
  logic [SW-1:0]   pop_stamp;
  logic [LW-1:0]   fifo_level;
  logic            bus_req;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] rate_divisor(input logic [2:0] code);
    case (code)
      3'h0:    rate_divisor = 7'h02;
      3'h1:    rate_divisor = 7'h04;
      3'h2:    rate_divisor = 7'h0c;
      3'h3:    rate_divisor = 7'h18;
      3'h4:    rate_divisor = 7'h06;
      3'h5:    rate_divisor = 7'h30;
      3'h6:    rate_divisor = 7'h60;
      default: rate_divisor = 7'h01;
    endcase
  endfunction

  function automatic logic rising(input logic [2:0] s);
    rising = s[1] && !s[2];
  endfunction

  function automatic logic falling(input logic [2:0] s);
    falling = !s[1] && s[2];
  endfunction

  function automatic logic reg_hit(input logic [7:0] adr,
                                   input logic [7:0] ofs);
    reg_hit = (adr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  assign ext_sel    = q.ctrl[`SIR_CTRL_EXT_CLK];
  assign fixed_mode = q.ctrl[`SIR_CTRL_FIXED];
  assign rate_code  = q.ctrl[`SIR_CTRL_RATE_MSB:`SIR_CTRL_RATE_LSB];
  assign divisor    = rate_divisor(rate_code);

  // Oscillator cell and the status power-down bit only; no other logic looks at this
  assign crystal_osc_pd_o = ext_sel || q.ctrl[`SIR_CTRL_OSC_PD];

  // ----------------------------------------------------------------
  // Edge detection on synchronised inputs
  // ----------------------------------------------------------------
  assign xclk_rise = rising(q.xclk_sync);
  assign xtal_rise = rising(q.xtal_sync);
  assign tx_fall   = falling(q.tx_sync);
  assign rx_fall   = falling(q.rx_sync);

  // Sample tick: external clock edge or divided crystal
  assign tick = ext_sel ? xclk_rise
                        : (xtal_rise &&
                           (q.div_cnt == divisor - 7'h01));

  // Modulation window inside the bit
  assign pulse_on = (q.enc_st == ENC_BIT) &&
                    (q.enc_cnt >= 4'(`SIR_ENC_PRE_TICKS)) &&
                    (q.enc_cnt < 4'(`SIR_ENC_PRE_TICKS +
                                    `SIR_ENC_HIGH_TICKS));

  // ----------------------------------------------------------------
  // Received pulse queue
  // ----------------------------------------------------------------
  assign fifo_rst = rst_i || !codec_reset_n_i;

  sir_pulse_fifo
  #(
    .WIDTH (SW),
    .DEPTH (FIFO_DEPTH)
  )
  u_pulse_fifo
  (
    .clk_i       (clk_i),
    .rst_i       (fifo_rst),
    .in_valid_i  (q.pend),
    .in_ready_o  (push_ready),
    .in_data_i   (q.pend_stamp),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_stamp),
    .level_o     (fifo_level)
  );

  // Stretcher takes the next pulse when idle or at the end of a bit
  assign pop_ready = (q.dec_st == DEC_IDLE) ||
                     (tick && q.dec_cnt == 4'(BIT_TICKS-1));

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign optical_tx_out_o = q.tx_out;
  assign serial_rx_out_o  = q.rx_out;
  assign wb_dat_o         = q.rdata;
  assign wb_ack_o         = q.ack;
  assign bus_req          = wb_cyc_i && wb_stb_i;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;

    // Two-stage synchronisers plus an edge history stage
    d.xclk_sync = {q.xclk_sync[1:0], ext_sample_clk_i};
    d.xtal_sync = {q.xtal_sync[1:0], crystal_clk_i};
    d.tx_sync   = {q.tx_sync[1:0], serial_tx_i};
    d.rx_sync   = {q.rx_sync[1:0], optical_rx_in_n_i};

    // Crystal divider
    if (ext_sel)
    begin
      d.div_cnt = '0;
    end
    else if (xtal_rise)
    begin
      if (q.div_cnt >= divisor - 7'h01)
      begin
        d.div_cnt = '0;
      end
      else
      begin
        d.div_cnt = q.div_cnt + 7'h01;
      end
    end

    if (tick)
    begin
      d.tick_cnt = q.tick_cnt + SW'(1);
    end

    // Encoder
    case (q.enc_st)
      ENC_IDLE:
      begin
        if (tx_fall)
        begin
          d.enc_st  = ENC_BIT;
          d.enc_cnt = '0;
        end
      end
      ENC_BIT:
      begin
        if (tick)
        begin
          if (q.enc_cnt == 4'(BIT_TICKS-1))
          begin
            // Roll into the next bit; it is judged a few ticks in
            d.enc_cnt = '0;
          end
          else if (q.enc_cnt == 4'h2 && q.tx_sync[2])
          begin
            // Line high inside the bit: a one, so no pulse
            d.enc_st = ENC_IDLE;
          end
          else
          begin
            d.enc_cnt = q.enc_cnt + 4'h1;
          end
        end
      end
      default:
      begin
        d.enc_st = ENC_IDLE;
      end
    endcase

    // Fixed-width pulse counts crystal edges, not sample ticks
    d.enc_hi = pulse_on;
    // Armed one above the width so the pulse spans whole crystal periods
    if (fixed_mode && pulse_on && !q.enc_hi)
    begin
      d.mono_cnt = 3'(MONO_XTAL + 1);
    end
    else if (q.mono_cnt != '0 && xtal_rise)
    begin
      d.mono_cnt = q.mono_cnt - 3'h1;
    end

    d.tx_out = fixed_mode ? (q.mono_cnt != '0 &&
                             q.mono_cnt != 3'(MONO_XTAL + 1))
                          : pulse_on;

    // Receive edge waits here until the queue accepts it
    if (rx_fall)
    begin
      d.pend       = 1'b1;
      d.pend_stamp = q.tick_cnt;
      d.rx_count   = q.rx_count + 8'h01;
    end
    else if (q.pend && push_ready)
    begin
      d.pend = 1'b0;
    end

    // Decoder: stretch each pulse to one bit time
    case (q.dec_st)
      DEC_IDLE:
      begin
        d.rx_out = 1'b1;
        if (pop_valid)
        begin
          d.dec_st     = DEC_STRETCH;
          d.dec_cnt    = '0;
          d.rx_out     = 1'b0;
          d.last_stamp = pop_stamp;
        end
      end
      DEC_STRETCH:
      begin
        if (tick)
        begin
          if (q.dec_cnt == 4'(BIT_TICKS-1))
          begin
            if (pop_valid)
            begin
              d.dec_cnt    = '0;
              d.last_stamp = pop_stamp;
            end
            else
            begin
              d.dec_st = DEC_IDLE;
              d.rx_out = 1'b1;
            end
          end
          else
          begin
            d.dec_cnt = q.dec_cnt + 4'h1;
          end
        end
      end
      default:
      begin
        d.dec_st = DEC_IDLE;
        d.rx_out = 1'b1;
      end
    endcase

    // Codec reset holds both machines idle
    if (!codec_reset_n_i)
    begin
      d.enc_st   = ENC_IDLE;
      d.enc_cnt  = '0;
      d.enc_hi   = 1'b0;
      d.mono_cnt = '0;
      d.tx_out   = 1'b0;
      d.dec_st   = DEC_IDLE;
      d.dec_cnt  = '0;
      d.rx_out   = 1'b1;
      d.pend     = 1'b0;
    end

    // Wishbone slave: one wait state, ack for one cycle
    d.ack = bus_req && !q.ack;
    if (bus_req && !q.ack)
    begin
      if (reg_hit(wb_adr_i, `SIR_OFS_CTRL))
      begin
        d.rdata = {{(32-`SIR_CTRL_W){1'b0}}, q.ctrl};
      end
      else if (reg_hit(wb_adr_i, `SIR_OFS_STATUS))
      begin
        d.rdata = '0;
        d.rdata[`SIR_STAT_ENC_BUSY] = (q.enc_st != ENC_IDLE);
        d.rdata[`SIR_STAT_DEC_BUSY] = (q.dec_st != DEC_IDLE);
        d.rdata[`SIR_STAT_OSC_PD]   = crystal_osc_pd_o;
        d.rdata[`SIR_STAT_PENDING]  = q.pend;
        d.rdata[`SIR_STAT_LEVEL_LSB +: LW] = fifo_level;
        d.rdata[`SIR_STAT_COUNT_LSB +: 8]  = q.rx_count;
        d.rdata[`SIR_STAT_STAMP_LSB +: SW] = q.last_stamp;
      end
      else
      begin
        d.rdata = '0;
      end
    end
    // Write lands on the edge where the master sees ack
    if (bus_req && q.ack && wb_we_i && wb_sel_i[0] &&
        reg_hit(wb_adr_i, `SIR_OFS_CTRL))
    begin
      d.ctrl = wb_dat_i[`SIR_CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q        <= '0;
      q.ctrl   <= `SIR_CTRL_RESET;
      q.rx_out <= 1'b1;
      q.enc_st <= ENC_IDLE;
      q.dec_st <= DEC_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

/* File: serial_infrared_pulse_codec_properties.sv */
`timescale 1ns/1ps
module sir_codec_properties
(
  // Clock and resets
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        codec_reset_n_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Pins
  input wire logic        ext_sample_clk_i,
  input wire logic        crystal_clk_i,
  input wire logic        crystal_osc_pd_o,
  input wire logic        serial_tx_i,
  input wire logic        serial_rx_out_o,
  input wire logic        optical_tx_out_o,
  input wire logic        optical_rx_in_n_i
);
  logic [5:0] ctrl_q;
  logic       ext_q;
  logic       xtal_q;
  logic [7:0] tk_q;
  logic [7:0] rk_q;
  logic       ext_rise;
  logic       xtal_rise;

  assign ext_rise  = ext_sample_clk_i && !ext_q;
  assign xtal_rise = crystal_clk_i && !xtal_q;

  // Shadow of the control word and tick counts over pulses
  always_ff @(posedge clk_i)
  begin
    ext_q  <= ext_sample_clk_i;
    xtal_q <= crystal_clk_i;
    tk_q   <= !optical_tx_out_o ? 8'h00
              : tk_q + 8'(ctrl_q[4] ? xtal_rise : ext_rise);
    rk_q   <= serial_rx_out_o ? 8'h00 : rk_q + 8'(ext_rise);
    if (rst_i)
      ctrl_q <= '0;
    else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
             && wb_adr_i == 8'h00)
      ctrl_q <= wb_dat_i[5:0];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence s_ack;
    !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o;
  endsequence

  a_ack_one_wait: assert property (s_req |-> s_ack)
    else $error("ack not one wait cycle");
  a_ack_with_req: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  a_osc_pd_follow: assert property (
    crystal_osc_pd_o == (ctrl_q[3] | ctrl_q[5]))
    else $error("oscillator power-down wrong");
  a_codec_clear: assert property (
    !codec_reset_n_i |=> !optical_tx_out_o && serial_rx_out_o)
    else $error("codec reset did not clear outputs");
  a_tx_in_bit: assert property (
    $rose(optical_tx_out_o) |-> !serial_tx_i)
    else $error("pulse outside a zero bit");
  a_tx_three_ticks: assert property (
    $fell(optical_tx_out_o) && ctrl_q[3] && !ctrl_q[4] |-> tk_q == 3)
    else $error("pulse not three ticks");
  a_mono_six: assert property (
    $fell(optical_tx_out_o) && ctrl_q[4] |-> tk_q == 6)
    else $error("fixed pulse not six crystal cycles");
  a_rx_stretch: assert property (
    $rose(serial_rx_out_o) && ctrl_q[3] && $past(codec_reset_n_i)
    |-> rk_q inside {[15:96]})
    else $error("stretched zero too short");
  a_rx_answer: assert property (
    $fell(optical_rx_in_n_i)
    |-> ##[1:8] (!serial_rx_out_o || !codec_reset_n_i))
    else $error("no receive zero after pulse");
endmodule

/* File: sir_far_end.sv */
`timescale 1ns/1ps
module sir_far_end
#(
  parameter int HALF = 4
)
(
  // Clock
  input  wire logic clk_i,
  // Toward the codec
  output logic      ext_sample_clk_o,
  output logic      crystal_clk_o,
  output logic      serial_tx_o,
  output logic      optical_rx_n_o
);
  int hc = 0;

  initial
  begin
    ext_sample_clk_o = 1'b0;
    crystal_clk_o = 1'b0;
    serial_tx_o = 1'b1;
    optical_rx_n_o = 1'b1;
  end

  // Baud output and crystal both run free
  always @(posedge clk_i)
  begin
    hc <= (hc == HALF - 1) ? 0 : hc + 1;
    if (hc == HALF - 1)
    begin
      ext_sample_clk_o <= !ext_sample_clk_o;
      crystal_clk_o <= !crystal_clk_o;
    end
  end

  // UART frame, bit 0 first, line idles high after it
  task automatic send_bits(input logic [9:0] b, input int n, input int t);
    for (int i = 0; i < n; i++)
    begin
      serial_tx_o <= b[i];
      repeat (t) @(posedge clk_i);
    end
    serial_tx_o <= 1'b1;
  endtask

  // Received optical pulse, active low, short or fixed width
  task automatic ir_pulse(input int w, input int gap);
    optical_rx_n_o <= 1'b0;
    repeat (w) @(posedge clk_i);
    optical_rx_n_o <= 1'b1;
    repeat (gap) @(posedge clk_i);
  endtask
endmodule

/* File: tb_serial_infrared_pulse_codec.sv */
`timescale 1ns/1ps
module tb_serial_infrared_pulse_codec;
  localparam int P = 8;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        codec_reset_n = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack, eclk, xclk, pd, txp, rxo, iro, irn;
  int          bad_count = 0, compares = 0, cycles = 0, hi = 0, lo = 0;
  int          tx_q[$], rx_q[$], exp_q[$];
  int          div_tab[8] = '{2, 4, 12, 24, 6, 48, 96, 1};

  always #4 clk_i = ~clk_i;

  serial_infrared_pulse_codec dut (.clk_i(clk_i), .rst_i(rst_i),
    .codec_reset_n_i(codec_reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ext_sample_clk_i(eclk), .crystal_clk_i(xclk),
    .crystal_osc_pd_o(pd), .serial_tx_i(txp), .serial_rx_out_o(rxo),
    .optical_tx_out_o(iro), .optical_rx_in_n_i(irn));
  sir_far_end far (.clk_i(clk_i), .ext_sample_clk_o(eclk),
    .crystal_clk_o(xclk), .serial_tx_o(txp), .optical_rx_n_o(irn));

  // Pulse width monitors and run limit
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    hi <= iro ? hi + 1 : 0;
    lo <= rxo ? 0 : lo + 1;
    if (!iro && hi > 0) tx_q.push_back(hi);
    if (rxo && lo > 0) rx_q.push_back(lo);
    if (cycles == 80000)
    begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_run(input int got, input int mn, input int mx);
    compares++;
    if (got < mn || got > mx)
    begin
      bad_count++;
      $display("Error %0t: width %0d outside %0d..%0d", $time, got, mn, mx);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
    check({31'h0, ack}, 32'h0000_0001);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Model: one pulse of width w per zero bit
  task automatic frame(input logic [9:0] b, input int n, input int t,
                       input int w);
    exp_q.delete();
    tx_q.delete();
    for (int i = 0; i < n; i++)
      if (!b[i]) exp_q.push_back(w);
    @(posedge clk_i);
    far.send_bits(b, n, t);
    repeat (t) @(posedge clk_i);
    check(tx_q.size(), exp_q.size());
    foreach (tx_q[i]) check_run(tx_q[i], exp_q[i], exp_q[i]);
  endtask

  initial
  begin
    void'($urandom(5144));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    wb(0, 8'h00, 32'h0000_0000, 4'hf);
    check(rd, 32'h0000_0000);
    wb(1, 8'h04, 32'h0000_00ff, 4'hf);
    wb(0, 8'h04, 32'h0000_0000, 4'hf);
    check(rd, 32'h0000_0000);
    wb(0, 8'h08, 32'h0000_0000, 4'hf);
    check(rd, 32'h0000_0000);
    wb(1, 8'h00, 32'h0000_0020, 4'hf);
    wb(1, 8'h00, 32'h0000_0000, 4'h0);
    wb(0, 8'h04, 32'h0000_0000, 4'hf);
    check({rd[2], pd}, 2'b11);
    wb(1, 8'h00, 32'h0000_0008, 4'hf);
    @(negedge clk_i);
    check(pd, 1'b1);
    // ----------------------------------------
    // External clock traffic
    // ----------------------------------------
    repeat (3) frame({1'b1, 8'($urandom), 1'b0}, 10, 16 * P, 3 * P);
    rx_q.delete();
    far.ir_pulse(3 * P, 200);
    far.ir_pulse(12, 200);
    for (int i = 0; i < 7; i++) far.ir_pulse(2, 4);
    wb(0, 8'h04, 32'h0000_0000, 4'hf);
    check(rd[6:3], 4'b1001);
    repeat (1000) @(posedge clk_i);
    // Queue of four plus one decoding plus one pending
    exp_q = '{1, 1, 1 + 4 + 1};
    check(rx_q.size(), exp_q.size());
    foreach (rx_q[i]) check_run(rx_q[i], exp_q[i] * 128 - 8, exp_q[i] * 128);
    far.ir_pulse(2, 20);
    codec_reset_n <= 1'b0;
    @(posedge clk_i);
    codec_reset_n <= 1'b1;
    @(posedge clk_i);
    check(rxo, 1'b1);
    // ----------------------------------------
    // Crystal clock, every rate code, then fixed pulses
    // ----------------------------------------
    for (int c = 0; c < 8; c++)
    begin
      wb(1, 8'h00, 32'(c), 4'hf);
      @(negedge clk_i);
      check(pd, 1'b0);
      frame(10'h000, 1, 16 * div_tab[c] * P, 3 * div_tab[c] * P);
    end
    wb(1, 8'h00, 32'h0000_0010, 4'hf);
    frame({1'b1, 8'($urandom), 1'b0}, 10, 32 * P, 6 * P);
    wb(1, 8'h00, 32'h0000_0012, 4'hf);
    frame(10'h000, 1, 192 * P, 6 * P);
    end_sim();
  end
endmodule

bind serial_infrared_pulse_codec sir_codec_properties chk (.clk_i(clk_i),
  .rst_i(rst_i), .codec_reset_n_i(codec_reset_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .ext_sample_clk_i(ext_sample_clk_i), .crystal_clk_i(crystal_clk_i),
  .crystal_osc_pd_o(crystal_osc_pd_o), .serial_tx_i(serial_tx_i),
  .serial_rx_out_o(serial_rx_out_o), .optical_tx_out_o(optical_tx_out_o),
  .optical_rx_in_n_i(optical_rx_in_n_i));
